// ### inc/wit_consts.vh
// Constants of the watchdog / interval timer: addresses, layouts, resets
// Assumes inclusion by bare name from the design files.
`ifndef WIT_CONSTS_VH
`define WIT_CONSTS_VH

`define WIT_ADDR_CTRL      32'hffff8610
`define WIT_ADDR_COUNT     32'hffff8611
`define WIT_ADDR_RST_WR    32'hffff8612
`define WIT_ADDR_RST_RD    32'hffff8613

`define WIT_SZ_BYTE        2'h0
`define WIT_SZ_WORD        2'h1
`define WIT_SZ_LONG        2'h2

`define WIT_CTRL_RESET     8'h18
`define WIT_COUNT_RESET    8'h00
`define WIT_RST_RESET      8'h1f
`define WIT_COUNT_MAX      8'hff
`define WIT_CTRL_FIXED     2'h3
`define WIT_RST_FIXED      6'h1f

`define WIT_BIT_FLAG       7
`define WIT_BIT_MODE       6
`define WIT_BIT_ENABLE     5
`define WIT_BIT_INTERNAL_RESET_ENABLE       6
`define WIT_CKS_HI         2
`define WIT_KEY_HI         15
`define WIT_KEY_LO         8

`define WIT_MODE_INTERVAL  1'h0
`define WIT_MODE_WATCHDOG  1'h1

`define WIT_PRE_WIDTH      13
`define WIT_EXP_0          1
`define WIT_EXP_1          6
`define WIT_EXP_2          7
`define WIT_EXP_3          8
`define WIT_EXP_4          9
`define WIT_EXP_5          10
`define WIT_EXP_6          12
`define WIT_EXP_7          13

`endif

// ### core/wit_prescaler.v
// Free-running prescaler giving one-cycle count enables for eight rates
// Assumes a single clock domain and synchronous active-high reset.
`timescale 1ns/1ns
`include "wit_consts.vh"

module wit_prescaler #(
  parameter WIDTH = `WIT_PRE_WIDTH
) (
  input  wire       clk,   // System clock
  input  wire       srst,  // Synchronous reset
  input  wire [2:0] sel,   // Clock select code
  output reg        tick   // One-cycle enable at selected rate
);

  reg [WIDTH-1:0] pre_r;

  always @(posedge clk) begin
    if (srst) begin
      pre_r <= {WIDTH{1'b0}};
    end else begin
      pre_r <= pre_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Divide by 2^n: all n low bits set marks the last cycle of each period
  always @* begin
    case (sel)
      3'h0:    tick = &pre_r[`WIT_EXP_0-1:0];
      3'h1:    tick = &pre_r[`WIT_EXP_1-1:0];
      3'h2:    tick = &pre_r[`WIT_EXP_2-1:0];
      3'h3:    tick = &pre_r[`WIT_EXP_3-1:0];
      3'h4:    tick = &pre_r[`WIT_EXP_4-1:0];
      3'h5:    tick = &pre_r[`WIT_EXP_5-1:0];
      3'h6:    tick = &pre_r[`WIT_EXP_6-1:0];
      default: tick = &pre_r[`WIT_EXP_7-1:0];
    endcase
  end

endmodule // wit_prescaler

// ### core/wit_stretch.v
// Stretches a one-cycle trigger into a level held for LEN cycles
// Assumes a single clock domain and synchronous active-high reset.
`timescale 1ns/1ns

module wit_stretch #(
  parameter LEN = 16
) (
  input  wire clk,   // System clock
  input  wire srst,  // Synchronous reset
  input  wire trig,  // One-cycle trigger
  output reg  level  // High for LEN cycles after trigger
);

  reg [15:0] cnt_r;

  always @(posedge clk) begin
    if (srst) begin
      cnt_r <= 16'h0000;
      level <= 1'b0;
    end else if (trig) begin
      cnt_r <= LEN[15:0] - 16'h0001;
      level <= 1'b1;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end else begin
      level <= 1'b0;
    end
  end

endmodule // wit_stretch

// ### core/wit_watchdog_unit.v
// Watchdog / interval timer: 8-bit counter, prescaler, flags and bus regs
// Assumes a CPU peripheral bus on clk with one-cycle access strobes.
//
// Function
// - Counter runs in either watchdog mode or interval timer mode.
// - Watchdog mode: overflow drives the active-low overflow output.
// - Watchdog overflow also resets the chip when internal reset is enabled.
// - Interval mode: overflow raises the interval interrupt instead of the pin.
// - Counter times standby recovery; its overflow ends standby.
// - Eight counting clocks, all derived from the system clock.
// - Counter is an 8-bit up-counter, readable and writable.
// - Counts selected clock pulses while timer enable is 1 and during standby recovery.
// - Overflow is the wrap from maximum to zero; mode picks its effect.
// - Counter clears on power-on reset and when a control write clears timer enable.
// - Standby entry keeps the counter value.
// - Registers are written only by 16-bit transfers.
// - Registers are read only by 8-bit transfers.
// - Status bit 7 takes only a written zero, clearing its flag.
// - Mode 0 is interval with interrupt; mode 1 is watchdog with pin.
// - Select codes give divide 2,64,128,256,512,1024,4096,8192; reset code 0.
// - Interval flag set by interval overflow; cleared by read-set then write 0.
// - Watchdog flag set only by overflow in watchdog mode.
`timescale 1ns/1ns
`include "wit_consts.vh"

module wit_watchdog_unit #(
  parameter [7:0] CTRL_KEY    = 8'hc3, // Arbitrary value
  parameter [7:0] COUNT_KEY   = 8'h3c, // Arbitrary value
  parameter [7:0] RST_KEY     = 8'h96, // Arbitrary value
  parameter       OVF_OUT_LEN = 128,
  parameter       RST_OUT_LEN = 512
) (
  input  wire        clk,                // System clock, 50 MHz
  input  wire        srst,               // Power-on reset, sync, high
  input  wire [31:0] bus_addr,           // Byte address
  input  wire        bus_wr,             // Write strobe
  input  wire        bus_rd,             // Read strobe
  input  wire [1:0]  bus_size,           // 0 byte, 1 word, 2 longword
  input  wire [15:0] bus_wdata,          // Write data: key high, value low
  output reg  [7:0]  bus_rdata,          // Read data
  output reg         bus_ack,            // Access done, one cycle
  output reg         bus_err,            // Access refused, one cycle
  input  wire        standby,            // Standby request level
  input  wire        wake,               // Standby wake event pulse
  output reg         standby_release,    // Recovery timing done, pulse
  output wire        overflow_out_n,     // Watchdog overflow pin, low active
  output wire        chip_reset_out,     // Internal chip reset request
  output wire        interval_interrupt  // Interval interrupt request
);

  localparam [1:0] ST_RUN    = 2'h0;
  localparam [1:0] ST_STBY   = 2'h1;
  localparam [1:0] ST_SETTLE = 2'h2;
  localparam [7:0] CTRL_RST  = `WIT_CTRL_RESET;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] count_r;
  reg [7:0] count_nxt;
  reg       ovf_r;
  reg       ovf_nxt;
  reg       ovf_arm_r;
  reg       ovf_arm_nxt;
  reg       mode_r;
  reg       mode_nxt;
  reg       tme_r;
  reg       tme_nxt;
  reg [2:0] cks_r;
  reg [2:0] cks_nxt;
  reg       watchdog_overflow_flag_r;
  reg       watchdog_overflow_flag_nxt;
  reg       watchdog_overflow_flag_arm_r;
  reg       watchdog_overflow_flag_arm_nxt;
  reg       internal_reset_enable_r;
  reg       internal_reset_enable_nxt;

  reg       hit_ctrl;
  reg       hit_count;
  reg       hit_rst_wr;
  reg       hit_rst_rd;

  wire       tick;
  wire       count_en;
  wire       wrap;
  wire       run_ovf;
  wire       wd_ovf;
  wire       int_ovf;
  wire       wr_word;
  wire       rd_byte;
  wire [7:0] key;
  wire       stby_enter;
  wire       ovf_level;
  wire [7:0] ctrl_rd;
  wire [7:0] rst_rd;

  // Address decode
  always @* begin
    hit_ctrl   = 1'b0;
    hit_count  = 1'b0;
    hit_rst_wr = 1'b0;
    hit_rst_rd = 1'b0;
    if (bus_addr == `WIT_ADDR_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (bus_addr == `WIT_ADDR_COUNT) begin
      hit_count = 1'b1;
    end else if (bus_addr == `WIT_ADDR_RST_WR) begin
      hit_rst_wr = 1'b1;
    end else if (bus_addr == `WIT_ADDR_RST_RD) begin
      hit_rst_rd = 1'b1;
    end
  end

  assign wr_word = bus_wr && (bus_size == `WIT_SZ_WORD);
  assign rd_byte = bus_rd && (bus_size == `WIT_SZ_BYTE);
  assign key     = bus_wdata[`WIT_KEY_HI:`WIT_KEY_LO];

  // Both the control and the counter are written at the control address;
  // the key byte picks which, so a stray byte store cannot hit either.
  wire wr_ctrl  = wr_word && hit_ctrl && (key == CTRL_KEY);
  wire wr_count = wr_word && hit_ctrl && (key == COUNT_KEY);
  wire wr_rst   = wr_word && hit_rst_wr && (key == RST_KEY);
  wire rd_ctrl  = rd_byte && hit_ctrl;
  wire rd_rst   = rd_byte && hit_rst_rd;

  wit_prescaler #(
    .WIDTH (`WIT_PRE_WIDTH)
  ) u_pre (
    .clk  (clk),
    .srst (srst),
    .sel  (cks_r),
    .tick (tick)
  );

  // Standby keeps counting off; recovery counts with the kept select code
  assign count_en = tick && (state_r != ST_STBY) &&
                    (tme_r || (state_r == ST_SETTLE));
  assign wrap     = count_en && (count_r == `WIT_COUNT_MAX);
  assign run_ovf  = wrap && (state_r == ST_RUN);
  assign wd_ovf   = run_ovf && (mode_r == `WIT_MODE_WATCHDOG);
  assign int_ovf  = run_ovf && (mode_r == `WIT_MODE_INTERVAL);
  assign stby_enter = standby && (state_r == ST_RUN);

  always @* begin
    state_nxt       = state_r;
    case (state_r)
      ST_RUN: begin
        if (standby) begin
          state_nxt = ST_STBY;
        end
      end
      ST_STBY: begin
        if (wake) begin
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (wrap) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // Control/status and counter next values
  always @* begin
    count_nxt   = count_r;
    ovf_nxt     = ovf_r;
    ovf_arm_nxt = ovf_arm_r;
    mode_nxt    = mode_r;
    tme_nxt     = tme_r;
    cks_nxt     = cks_r;
    if (count_en) begin
      count_nxt = count_r + 8'h01;
    end
    if (wr_count) begin
      count_nxt = bus_wdata[7:0];
    end
    if (wr_ctrl) begin
      mode_nxt = bus_wdata[`WIT_BIT_MODE];
      tme_nxt  = bus_wdata[`WIT_BIT_ENABLE];
      cks_nxt  = bus_wdata[`WIT_CKS_HI:0];
      if (!bus_wdata[`WIT_BIT_ENABLE]) begin
        count_nxt = `WIT_COUNT_RESET;
      end
      if (!bus_wdata[`WIT_BIT_FLAG] && ovf_arm_r) begin
        ovf_nxt = 1'b0;
      end
      ovf_arm_nxt = 1'b0;
    end
    if (rd_ctrl && ovf_r) begin
      ovf_arm_nxt = 1'b1;
    end
    if (stby_enter) begin
      // Upper control bits drop, select code and count are kept
      ovf_nxt     = 1'b0;
      ovf_arm_nxt = 1'b0;
      mode_nxt    = `WIT_MODE_INTERVAL;
      tme_nxt     = 1'b0;
    end
    if (wd_ovf) begin
      // Timer restarts from its reset state after a watchdog bite
      count_nxt   = `WIT_COUNT_RESET;
      ovf_nxt     = CTRL_RST[`WIT_BIT_FLAG];
      ovf_arm_nxt = 1'b0;
      mode_nxt    = `WIT_MODE_INTERVAL;
      tme_nxt     = 1'b0;
      cks_nxt     = CTRL_RST[`WIT_CKS_HI:0];
    end
    if (int_ovf) begin
      ovf_nxt = 1'b1;
    end
  end

  // Reset control/status next values
  always @* begin
    watchdog_overflow_flag_nxt     = watchdog_overflow_flag_r;
    watchdog_overflow_flag_arm_nxt = watchdog_overflow_flag_arm_r;
    internal_reset_enable_nxt     = internal_reset_enable_r;
    if (wr_rst) begin
      internal_reset_enable_nxt = bus_wdata[`WIT_BIT_INTERNAL_RESET_ENABLE];
      if (!bus_wdata[`WIT_BIT_FLAG] && watchdog_overflow_flag_arm_r) begin
        watchdog_overflow_flag_nxt = 1'b0;
      end
      watchdog_overflow_flag_arm_nxt = 1'b0;
    end
    if (rd_rst && watchdog_overflow_flag_r) begin
      watchdog_overflow_flag_arm_nxt = 1'b1;
    end
    if (stby_enter) begin
      watchdog_overflow_flag_nxt     = 1'b0;
      watchdog_overflow_flag_arm_nxt = 1'b0;
      internal_reset_enable_nxt     = 1'b0;
    end
    // Set wins over a clear in the same cycle; not touched by own reset
    if (wd_ovf) begin
      watchdog_overflow_flag_nxt = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      state_r    <= ST_RUN;
      count_r    <= `WIT_COUNT_RESET;
      ovf_r      <= 1'b0;
      ovf_arm_r  <= 1'b0;
      mode_r     <= `WIT_MODE_INTERVAL;
      tme_r      <= 1'b0;
      cks_r      <= CTRL_RST[`WIT_CKS_HI:0];
      watchdog_overflow_flag_r     <= 1'b0;
      watchdog_overflow_flag_arm_r <= 1'b0;
      internal_reset_enable_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      count_r    <= count_nxt;
      ovf_r      <= ovf_nxt;
      ovf_arm_r  <= ovf_arm_nxt;
      mode_r     <= mode_nxt;
      tme_r      <= tme_nxt;
      cks_r      <= cks_nxt;
      watchdog_overflow_flag_r     <= watchdog_overflow_flag_nxt;
      watchdog_overflow_flag_arm_r <= watchdog_overflow_flag_arm_nxt;
      internal_reset_enable_r     <= internal_reset_enable_nxt;
    end
  end

  assign ctrl_rd = {ovf_r, mode_r, tme_r, `WIT_CTRL_FIXED, cks_r};
  assign rst_rd  = {watchdog_overflow_flag_r, internal_reset_enable_r, `WIT_RST_FIXED};

  // Bus answer one cycle after the strobe; wrong sizes and keys are refused
  always @(posedge clk) begin
    if (srst) begin
      bus_rdata       <= 8'h00;
      bus_ack         <= 1'b0;
      bus_err         <= 1'b0;
      standby_release <= 1'b0;
    end else begin
      bus_ack         <= bus_rd || bus_wr;
      bus_err         <= (bus_rd && !(rd_byte && (hit_ctrl || hit_count || hit_rst_rd))) ||
                         (bus_wr && !(wr_ctrl || wr_count || wr_rst));
      standby_release <= wrap && (state_r == ST_SETTLE);
      if (rd_byte && hit_ctrl) begin
        bus_rdata <= ctrl_rd;
      end else if (rd_byte && hit_count) begin
        bus_rdata <= count_r;
      end else if (rd_byte && hit_rst_rd) begin
        bus_rdata <= rst_rd;
      end else if (bus_rd) begin
        bus_rdata <= 8'h00;
      end
    end
  end

  // A bite outlives the one-cycle event so the pin and reset are seen
  wit_stretch #(
    .LEN (OVF_OUT_LEN)
  ) u_ovf_pin (
    .clk   (clk),
    .srst  (srst),
    .trig  (wd_ovf),
    .level (ovf_level)
  );

  wit_stretch #(
    .LEN (RST_OUT_LEN)
  ) u_chip_rst (
    .clk   (clk),
    .srst  (srst),
    .trig  (wd_ovf && internal_reset_enable_r),
    .level (chip_reset_out)
  );

  assign overflow_out_n     = ~ovf_level;
  assign interval_interrupt = ovf_r;

endmodule // wit_watchdog_unit

// ### test/wit_checker.sv
// Checker of the watchdog / interval timer ports: bus answers, pins, flags
// Assumes binding to the unit's top module; one clock, sync reset high.
`timescale 1ns/1ns
module wit_checker #(
  parameter OVF_OUT_LEN = 128
) (
  input wire logic        clk,                // Clock
  input wire logic        srst,               // Reset
  input wire logic [31:0] bus_addr,           // Address
  input wire logic        bus_wr,             // Write strobe
  input wire logic        bus_rd,             // Read strobe
  input wire logic [1:0]  bus_size,           // Size code
  input wire logic [7:0]  bus_rdata,          // Read data
  input wire logic        bus_ack,            // Done
  input wire logic        bus_err,            // Refused
  input wire logic        standby,            // Standby level
  input wire logic        standby_release,    // Recovery done
  input wire logic        overflow_out_n,     // Overflow pin
  input wire logic        chip_reset_out,     // Chip reset
  input wire logic        interval_interrupt  // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  int low_cnt;
  // Counts low cycles of the pin so its pulse width can be checked exactly
  always @(posedge clk) begin
    if (srst || overflow_out_n) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  ack_follow_a: assert property ((bus_wr || bus_rd) |=> bus_ack)
    else $error("access not answered next cycle");
  no_spur_ack_a: assert property (!(bus_wr || bus_rd) |=> !bus_ack && !bus_err)
    else $error("answer without access");
  wr_size_a: assert property (bus_wr && bus_size != 2'h1 |=> bus_err)
    else $error("non-word write accepted");
  rd_size_a: assert property (bus_rd && bus_size != 2'h0 |=> bus_err && bus_rdata == 8'h00)
    else $error("non-byte read accepted");
  unmapped_rd_a: assert property (bus_rd && bus_addr == 32'hffff8612 |=> bus_err)
    else $error("read of write-only address accepted");
  pin_len_a: assert property ($rose(overflow_out_n) |-> low_cnt == OVF_OUT_LEN)
    else $error("overflow pin pulse width wrong");
  pin_max_a: assert property (low_cnt <= OVF_OUT_LEN)
    else $error("overflow pin held low too long");
  irq_no_pin_a: assert property ($rose(interval_interrupt) |-> overflow_out_n)
    else $error("pin driven on interval overflow");
  rst_with_pin_a: assert property ($rose(chip_reset_out) |-> !overflow_out_n)
    else $error("chip reset without pin overflow");
  irq_clear_a: assert property ($fell(interval_interrupt) |-> $past(bus_wr) || $past(standby))
    else $error("interrupt dropped without a write");
  release_pulse_a: assert property (standby_release |=> !standby_release)
    else $error("release longer than one cycle");
  cover property ($rose(interval_interrupt));
  cover property ($fell(overflow_out_n));
  cover property (standby_release);
endmodule // wit_checker

// ### test/wit_cpu_model.sv
// CPU model: one-cycle strobes on the peripheral bus, then waits for the ack
// Assumes the unit acks within four cycles; released lines show inverted data.
`timescale 1ns/1ns
module wit_cpu_model (
  input  wire logic        clk,       // Clock
  input  wire logic [7:0]  bus_rdata, // Read data
  input  wire logic        bus_ack,   // Done
  input  wire logic        bus_err,   // Refused
  output logic      [31:0] bus_addr,  // Address
  output logic             bus_wr,    // Write strobe
  output logic             bus_rd,    // Read strobe
  output logic      [1:0]  bus_size,  // Size code
  output logic      [15:0] bus_wdata  // Key and value
);
  initial begin
    bus_addr = 32'h00000000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_size = 2'h0;
    bus_wdata = 16'h0000;
  end
  task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] sz,
                     input logic [15:0] d, output logic [7:0] q, output logic e);
    int n;
    @(posedge clk);
    bus_wr <= w;
    bus_rd <= !w;
    bus_addr <= a;
    bus_size <= sz;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
    n = 0;
    @(negedge clk);
    while (bus_ack !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    q = bus_rdata;
    e = (bus_ack === 1'b1) ? bus_err : 1'bx;
  endtask
endmodule // wit_cpu_model

// ### test/watchdog_interval_timer_tb.sv
// Testbench: register access, counting rates, both overflow modes, standby
// Assumes short pin and reset pulse lengths so the run stays brief.
`timescale 1ns/1ns
`include "wit_consts.vh"
module watchdog_interval_timer_tb;
  localparam logic [7:0] KC = 8'hc3; // Arbitrary key value
  localparam logic [7:0] KN = 8'h3c; // Arbitrary key value
  localparam logic [7:0] KR = 8'h96; // Arbitrary key value
  logic        clk, srst, standby, wake, bus_wr, bus_rd, bus_ack, bus_err, e;
  logic        standby_release, overflow_out_n, chip_reset_out, interval_interrupt;
  logic [31:0] bus_addr;
  logic [1:0]  bus_size;
  logic [15:0] bus_wdata;
  logic [7:0]  bus_rdata, q;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, n;
  int          dv[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
  wit_cpu_model cpu (.clk(clk), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_size(bus_size),
    .bus_wdata(bus_wdata));
  wit_watchdog_unit #(.CTRL_KEY(KC), .COUNT_KEY(KN), .RST_KEY(KR), .OVF_OUT_LEN(2),
    .RST_OUT_LEN(4)) uut (.clk(clk), .srst(srst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_size(bus_size), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .bus_err(bus_err), .standby(standby), .wake(wake),
    .standby_release(standby_release), .overflow_out_n(overflow_out_n),
    .chip_reset_out(chip_reset_out), .interval_interrupt(interval_interrupt));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out;
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    cmp_count++;
    if (got !== ex) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] k, input logic [7:0] v,
                    input logic ee = 1'b0, input logic [1:0] sz = `WIT_SZ_WORD);
    cpu.acc(1'b1, a, sz, {k, v}, q, e);
    chk("write refused", {7'h0, ee}, {7'h0, e});
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] ev, input logic ee = 1'b0,
                    input logic [1:0] sz = `WIT_SZ_BYTE);
    cpu.acc(1'b0, a, sz, 16'h0000, q, e);
    chk("read refused", {7'h0, ee}, {7'h0, e});
    chk("read data", ev, q);
  endtask
  // Waits on interrupt (0), pin low (1) or recovery pulse (2), counting cycles in n
  task automatic wait_hit(input int s, input int lim);
    n = 0;
    while ((s == 0 ? interval_interrupt : s == 1 ? !overflow_out_n : standby_release) !== 1'b1
           && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  initial begin
    srst = 1'b1;
    standby = 1'b0;
    wake = 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(`WIT_ADDR_CTRL, 8'h18);
    rd(`WIT_ADDR_COUNT, 8'h00);
    rd(`WIT_ADDR_RST_RD, 8'h1f);
    rd(`WIT_ADDR_RST_WR, 8'h00, 1'b1);
    rd(`WIT_ADDR_COUNT, 8'h00, 1'b1, `WIT_SZ_WORD);
    rd(`WIT_ADDR_COUNT, 8'h00, 1'b1, `WIT_SZ_LONG);
    wr(`WIT_ADDR_CTRL, KN, 8'h55);
    wr(`WIT_ADDR_CTRL, KN, 8'h99, 1'b1, `WIT_SZ_BYTE);
    wr(`WIT_ADDR_CTRL, KN, 8'h99, 1'b1, `WIT_SZ_LONG);
    wr(`WIT_ADDR_CTRL, 8'h5a, 8'h99, 1'b1);
    rd(`WIT_ADDR_COUNT, 8'h55);
    for (int c = 0; c < 8; c++) begin
      wr(`WIT_ADDR_CTRL, KN, 8'hfe);
      wr(`WIT_ADDR_CTRL, KC, 8'h38 | 8'(c));
      wait_hit(0, 2 * dv[c] + 8);
      // Two ticks from 8'hfe; the prescaler phase puts the wrap within one period
      chk("overflow span", 8'h1, {7'h0, n >= dv[c] + 1 && n <= 2 * dv[c]});
      chk("pin idle", 8'h1, {7'h0, overflow_out_n});
      rd(`WIT_ADDR_CTRL, 8'hb8 | 8'(c));
      wr(`WIT_ADDR_CTRL, KC, 8'hb8 | 8'(c));
      chk("flag kept", 8'h1, {7'h0, interval_interrupt});
      rd(`WIT_ADDR_CTRL, 8'hb8 | 8'(c));
      wr(`WIT_ADDR_CTRL, KC, 8'h18);
      chk("flag cleared", 8'h0, {7'h0, interval_interrupt});
      rd(`WIT_ADDR_COUNT, 8'h00);
    end
    for (int r = 1; r >= 0; r--) begin
      wr(`WIT_ADDR_RST_WR, KR, r[0] ? 8'h40 : 8'h00);
      wr(`WIT_ADDR_CTRL, KN, 8'hfe);
      wr(`WIT_ADDR_CTRL, KC, 8'h78);
      wait_hit(1, 20);
      chk("pin low", 8'h1, {7'h0, n < 20});
      @(negedge clk);
      chk("chip reset", {7'h0, r[0]}, {7'h0, chip_reset_out});
      chk("no interrupt", 8'h0, {7'h0, interval_interrupt});
      rd(`WIT_ADDR_RST_RD, r[0] ? 8'hdf : 8'h9f);
      rd(`WIT_ADDR_CTRL, 8'h18);
      wr(`WIT_ADDR_RST_WR, KR, 8'h00);
      rd(`WIT_ADDR_RST_RD, 8'h1f);
    end
    wr(`WIT_ADDR_CTRL, KN, 8'h40);
    @(posedge clk);
    standby <= 1'b1;
    repeat (3) @(posedge clk);
    standby <= 1'b0;
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wait_hit(2, 600);
    // 192 ticks at divide 2 from the kept 8'h40; a cleared count would need 256
    chk("recovery span", 8'h1, {7'h0, n >= 382 && n <= 386});
    close_out();
  end
endmodule // watchdog_interval_timer_tb
bind wit_watchdog_unit wit_checker #(.OVF_OUT_LEN(OVF_OUT_LEN)) chk_i (.clk(clk), .srst(srst),
  .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_size(bus_size),
  .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err), .standby(standby),
  .standby_release(standby_release), .overflow_out_n(overflow_out_n),
  .chip_reset_out(chip_reset_out), .interval_interrupt(interval_interrupt));
